// File: rtl/xbp_device.sv
// Device end of the external bus port: master, slave and boot strap
`timescale 1ns/1ps
module xbp_device
    import xbp_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // Bus mastership from arbitration
    input  wire logic        BUS_MASTER,
    // Master request
    input  wire logic        REQ_VALID,
    output logic             REQ_READY,
    input  wire logic        REQ_WRITE,
    input  wire logic        REQ_LONG,
    input  wire logic        REQ_ZONE32,
    input  wire logic        REQ_BOOT,
    input  wire logic        REQ_BURST,
    input  wire logic [31:0] REQ_ADDR,
    input  wire logic [63:0] REQ_WDATA,
    output logic             XFER_DONE,
    // Read return
    output logic             RD_VALID,
    input  wire logic        RD_READY,
    output logic [63:0]      RD_DATA,
    // Slave side
    input  wire logic        SLV_WAIT,
    output logic             SLV_DONE,
    output logic [3:0]       SLV_INDEX,
    // Boot strap
    output logic             EPROM_BOOT_STRAP,
    // Bus
    xbp_if.dev_end           bus
);
    typedef struct packed {
        xbp_end_t                                  e;
        logic                                      bms_n;
        logic                                      ms0_n;
        logic                                      ms1_n;
        logic                                      msh_n;
        logic                                      bms1;
        logic                                      bms2;
        logic                                      strap;
        logic [`XBP_DMEM_AW-1:0]                   sidx;
        logic [(1<<`XBP_DMEM_AW)-1:0][63:0]        mem;
    } xbp_dev_st_t;

    xbp_dev_st_t st;
    xbp_dev_st_t next_st;
    logic        fifo_in_ready;
    logic        slv_act;
    logic        take;

    assign take      = REQ_VALID && REQ_READY;
    assign REQ_READY = BUS_MASTER && (st.e.mst == M_IDLE) && (REQ_WRITE || fifo_in_ready);
    assign slv_act   = !BUS_MASTER && !(&st.e.c2[5:3]);

    xbp_fifo #(
        .WIDTH (`XBP_DATA_W),
        .DEPTH (`XBP_FIFO_DEPTH)
    ) i_xbp_fifo (
        .MCLK      (MCLK),
        .RST_N     (RST_N),
        .IN_VALID  (st.e.rvalid),
        .IN_READY  (fifo_in_ready),
        .IN_DATA   (st.e.rdata),
        .OUT_VALID (RD_VALID),
        .OUT_READY (RD_READY),
        .OUT_DATA  (RD_DATA)
    );

    always_comb begin
        next_st = st;
        // Two-stage pin synchronisers
        next_st.e.a1   = bus.addr;
        next_st.e.a2   = st.e.a1;
        next_st.e.d1   = bus.data;
        next_st.e.d2   = st.e.d1;
        next_st.e.c1   = {bus.rd_n, bus.wrl_n, bus.wrh_n, bus.burst_indicator_n_n, bus.ack, 1'b1};
        next_st.e.c2   = st.e.c1;
        next_st.bms1   = bus.bms_n;
        next_st.bms2   = st.bms1;
        next_st.e.rvalid = 1'b0;
        next_st.e.sdone  = 1'b0;

        unique case (st.e.mst)
            M_IDLE: begin
                if (take) begin
                    next_st.e.addr    = REQ_ADDR;
                    next_st.e.wdata   = REQ_WDATA;
                    next_st.e.write   = REQ_WRITE;
                    next_st.e.data_oe = REQ_WRITE;
                    // Strobes and selects load in the same edge as the address
                    next_st.e.rd_n  = REQ_WRITE;
                    next_st.e.wrl_n = !(REQ_WRITE && (REQ_ZONE32 || !REQ_ADDR[0] || REQ_LONG));
                    next_st.e.wrh_n = !(REQ_WRITE && !REQ_ZONE32 && (REQ_LONG || REQ_ADDR[0]));
                    next_st.e.burst_indicator_n_n = !REQ_BURST;
                    next_st.bms_n = !REQ_BOOT;
                    next_st.ms0_n = !(REQ_ADDR[31:27] == `XBP_BANK0_CODE);
                    next_st.ms1_n = !(REQ_ADDR[31:27] == `XBP_BANK1_CODE);
                    next_st.msh_n = !REQ_ADDR[31];
                    next_st.e.cnt = 4'h0;
                    next_st.e.mst = M_WAIT;
                end
            end
            M_WAIT: begin
                if (st.e.cnt != `XBP_CNT_MAX) begin
                    next_st.e.cnt = st.e.cnt + 4'h1;
                end
                // Settle covers both synchroniser delays before ack is trusted
                if ((st.e.cnt >= `XBP_ACK_SETTLE - 4'h1) && st.e.c2[1]) begin
                    next_st.e.rdata  = st.e.d2;
                    next_st.e.rvalid = !st.e.write;
                    next_st.e.rd_n   = 1'b1;
                    next_st.e.wrl_n  = 1'b1;
                    next_st.e.wrh_n  = 1'b1;
                    next_st.e.cnt    = 4'h0;
                    next_st.e.mst    = M_GAP;
                end
            end
            M_GAP: begin
                next_st.e.cnt = st.e.cnt + 4'h1;
                // Write data held so the slave sees the strobe rise first
                if (st.e.cnt == `XBP_GAP_CYC - 4'h1) begin
                    next_st.e.data_oe = 1'b0;
                    next_st.e.mst     = M_IDLE;
                end
            end
        endcase

        // Slave access by a host or another master
        next_st.e.sact  = slv_act;
        next_st.e.ackoe = slv_act && SLV_WAIT;
        if (slv_act && !st.e.sact) begin
            if (!st.e.sburst) begin
                next_st.sidx = st.e.a2[`XBP_DMEM_AW-1:0];
            end
            next_st.e.sburst = !st.e.c2[2];
        end
        if (slv_act) begin
            next_st.e.shold  = st.e.d2;
            next_st.e.slanes = {!st.e.c2[3], !st.e.c2[4]};
        end
        next_st.e.sdoe  = slv_act && !st.e.c2[5];
        next_st.e.sdout = st.mem[st.sidx];
        if (!slv_act && st.e.sact) begin
            if (st.e.slanes[0]) begin
                next_st.mem[st.sidx][`XBP_HALF_W-1:0] = st.e.shold[`XBP_HALF_W-1:0];
            end
            if (st.e.slanes[1]) begin
                next_st.mem[st.sidx][`XBP_DATA_W-1:`XBP_HALF_W] =
                    st.e.shold[`XBP_DATA_W-1:`XBP_HALF_W];
            end
            next_st.sidx    = st.sidx + 1'b1;
            next_st.e.sdone = 1'b1;
        end
        if (!st.e.sact && !slv_act && st.e.c2[2]) begin
            next_st.e.sburst = 1'b0;
        end

        if (!RST_N) begin
            next_st.e.mst     = M_IDLE;
            next_st.e.cnt     = 4'h0;
            next_st.e.write   = 1'b0;
            next_st.e.data_oe = 1'b0;
            next_st.e.rd_n    = 1'b1;
            next_st.e.wrl_n   = 1'b1;
            next_st.e.wrh_n   = 1'b1;
            next_st.e.burst_indicator_n_n  = 1'b1;
            next_st.e.addr    = '0;
            next_st.e.wdata   = '0;
            next_st.e.rdata   = '0;
            next_st.e.rvalid  = 1'b0;
            next_st.e.sact    = 1'b0;
            next_st.e.sburst  = 1'b0;
            next_st.e.sdoe    = 1'b0;
            next_st.e.ackoe   = 1'b0;
            next_st.e.slanes  = 2'h0;
            next_st.e.sdone   = 1'b0;
            next_st.bms_n     = 1'b1;
            next_st.ms0_n     = 1'b1;
            next_st.ms1_n     = 1'b1;
            next_st.msh_n     = 1'b1;
            next_st.sidx      = '0;
            // Pin released while in reset, so the pull level is the strap
            next_st.strap     = st.bms2;
        end
    end

    always_ff @(posedge MCLK) begin
        st <= next_st;
    end

    // Outputs float unless this end owns the bus and is out of reset; as slave it drives data on reads and pulls ack
    assign bus.d_ctl_oe  = BUS_MASTER && RST_N;
    assign bus.d_data_oe = (BUS_MASTER && RST_N && st.e.data_oe) || st.e.sdoe;
    assign bus.d_addr    = st.e.addr;
    assign bus.d_data    = st.e.sdoe ? st.e.sdout : st.e.wdata;
    assign bus.d_rd_n    = st.e.rd_n;
    assign bus.d_wrl_n   = st.e.wrl_n;
    assign bus.d_wrh_n   = st.e.wrh_n;
    assign bus.d_burst_indicator_n_n  = st.e.burst_indicator_n_n;
    assign bus.d_bms_n   = st.bms_n;
    assign bus.d_ms0_n   = st.ms0_n;
    assign bus.d_ms1_n   = st.ms1_n;
    assign bus.d_msh_n   = st.msh_n;
    assign bus.d_ack_oe  = st.e.ackoe && RST_N;

    assign XFER_DONE        = (st.e.mst == M_GAP) && (st.e.cnt == 4'h0);
    assign SLV_DONE         = st.e.sdone;
    assign SLV_INDEX        = st.sidx;
    assign EPROM_BOOT_STRAP = st.strap;
endmodule : xbp_device

// File: rtl/xbp_defs.svh
// Constants of the external bus port: decodes, timing counts, depths
// Behaviour
// - Master drives 32-bit address on pins
// - As slave, address pins are inputs
// - 64-bit two-way data bus
// - Master asserts read strobe on reads
// - As slave, read strobe marks reads
// - Strobes and selects change with address
// - Write-low on even words and agents
// - Write-low on every 32-bit zone write
// - Write-high on long or odd words
// - External master strobes low/high word lanes
// - As slave, write strobes mark writes
// - Slaves stretch with ack; master waits
// - Device as slave may hold ack low
// - Master drives boot memory chip select
// - Boot select pin sampled as reset strap
// - Bank 0 select on top bits 00110
// - Bank 1 select on top bits 00111
// - Host select when address bit 31 set
// - Only bus master drives address and strobes
// - Master asserts burst on consecutive addresses
// - Burst slave ignores later addresses, counts
// - Device slave increments address during burst
`ifndef XBP_DEFS_SVH
`define XBP_DEFS_SVH

`define XBP_ADDR_W      32
`define XBP_DATA_W      64
`define XBP_HALF_W      32
`define XBP_BANK0_CODE  5'h06
`define XBP_BANK1_CODE  5'h07
`define XBP_ACK_SETTLE  4'h8
`define XBP_GAP_CYC     4'h3
`define XBP_CNT_MAX     4'hF
`define XBP_DMEM_AW     4
`define XBP_HMEM_AW     2
`define XBP_FIFO_DEPTH  8

`endif

// File: rtl/xbp_pkg.sv
// Types shared by both ends of the external bus port
`include "xbp_defs.svh"
package xbp_pkg;

    typedef enum logic [1:0] {M_IDLE, M_WAIT, M_GAP} xbp_mst_t;

    // Pin group order: rd, wrl, wrh, burst_indicator_n, ack, msh
    typedef logic [5:0] xbp_pins_t;

    typedef struct packed {
        xbp_mst_t                              mst;
        logic [3:0]                            cnt;
        logic [`XBP_ADDR_W-1:0]                addr;
        logic [`XBP_DATA_W-1:0]                wdata;
        logic                                  write;
        logic                                  data_oe;
        logic                                  rd_n;
        logic                                  wrl_n;
        logic                                  wrh_n;
        logic                                  burst_indicator_n_n;
        logic [`XBP_DATA_W-1:0]                rdata;
        logic                                  rvalid;
        logic [`XBP_ADDR_W-1:0]                a1;
        logic [`XBP_ADDR_W-1:0]                a2;
        logic [`XBP_DATA_W-1:0]                d1;
        logic [`XBP_DATA_W-1:0]                d2;
        xbp_pins_t                             c1;
        xbp_pins_t                             c2;
        logic                                  sact;
        logic                                  sburst;
        logic                                  sdoe;
        logic [`XBP_DATA_W-1:0]                sdout;
        logic [`XBP_DATA_W-1:0]                shold;
        logic [1:0]                            slanes;
        logic                                  ackoe;
        logic                                  sdone;
    } xbp_end_t;

endpackage : xbp_pkg

// File: rtl/xbp_if.sv
// Shared external bus wires with pin resolution for both ends
`timescale 1ns/1ps
interface xbp_if;
    logic [31:0] d_addr;
    logic [31:0] h_addr;
    logic [31:0] addr;
    logic [63:0] d_data;
    logic [63:0] h_data;
    logic [63:0] data;
    logic        d_rd_n, d_wrl_n, d_wrh_n, d_burst_indicator_n_n;
    logic        h_rd_n, h_wrl_n, h_wrh_n, h_burst_indicator_n_n;
    logic        rd_n, wrl_n, wrh_n, burst_indicator_n_n;
    logic        d_bms_n, d_ms0_n, d_ms1_n, d_msh_n;
    logic        bms_n, ms0_n, ms1_n, msh_n;
    logic        bms_pull_n;
    logic        d_ctl_oe, d_data_oe, h_ctl_oe, h_data_oe;
    logic        d_ack_oe, h_ack_oe, ack;

    // Undriven lines float to their pullups
    assign addr   = d_ctl_oe ? d_addr : (h_ctl_oe ? h_addr : '1);
    assign data   = d_data_oe ? d_data : (h_data_oe ? h_data : '1);
    assign rd_n   = d_ctl_oe ? d_rd_n : (h_ctl_oe ? h_rd_n : 1'b1);
    assign wrl_n  = d_ctl_oe ? d_wrl_n : (h_ctl_oe ? h_wrl_n : 1'b1);
    assign wrh_n  = d_ctl_oe ? d_wrh_n : (h_ctl_oe ? h_wrh_n : 1'b1);
    assign burst_indicator_n_n = d_ctl_oe ? d_burst_indicator_n_n : (h_ctl_oe ? h_burst_indicator_n_n : 1'b1);
    assign bms_n  = d_ctl_oe ? d_bms_n : bms_pull_n;
    assign ms0_n  = d_ctl_oe ? d_ms0_n : 1'b1;
    assign ms1_n  = d_ctl_oe ? d_ms1_n : 1'b1;
    assign msh_n  = d_ctl_oe ? d_msh_n : 1'b1;
    assign ack    = ~(d_ack_oe | h_ack_oe);

    modport dev_end (
        output d_addr, d_data, d_rd_n, d_wrl_n, d_wrh_n, d_burst_indicator_n_n,
        output d_bms_n, d_ms0_n, d_ms1_n, d_msh_n, d_ctl_oe, d_data_oe, d_ack_oe,
        input  addr, data, rd_n, wrl_n, wrh_n, burst_indicator_n_n, bms_n, ack
    );
    modport host_end (
        output h_addr, h_data, h_rd_n, h_wrl_n, h_wrh_n, h_burst_indicator_n_n,
        output h_ctl_oe, h_data_oe, h_ack_oe,
        input  addr, data, rd_n, wrl_n, wrh_n, burst_indicator_n_n, msh_n, ack
    );
endinterface : xbp_if

// File: rtl/xbp_fifo.sv
// Parameterised valid/ready FIFO for the read return path
`timescale 1ns/1ps
module xbp_fifo
    import xbp_pkg::*;
#(
    parameter int WIDTH = `XBP_DATA_W,
    parameter int DEPTH = `XBP_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             MCLK,
    input  wire logic             RST_N,
    // Fill side
    input  wire logic             IN_VALID,
    output logic                  IN_READY,
    input  wire logic [WIDTH-1:0] IN_DATA,
    // Drain side
    output logic                  OUT_VALID,
    input  wire logic             OUT_READY,
    output logic [WIDTH-1:0]      OUT_DATA
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } xbp_fifo_st_t;

    xbp_fifo_st_t st;
    xbp_fifo_st_t next_st;

    assign IN_READY  = ~((st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]));
    assign OUT_VALID = (st.wp != st.rp);
    assign OUT_DATA  = st.mem[st.rp[AW-1:0]];

    always_comb begin
        next_st = st;
        if (IN_VALID && IN_READY) begin
            next_st.mem[st.wp[AW-1:0]] = IN_DATA;
            next_st.wp = st.wp + 1'b1;
        end
        if (OUT_VALID && OUT_READY) begin
            next_st.rp = st.rp + 1'b1;
        end
        if (!RST_N) begin
            next_st.wp = '0;
            next_st.rp = '0;
        end
    end

    always_ff @(posedge MCLK) begin
        st <= next_st;
    end
endmodule : xbp_fifo

// File: rtl/xbp_host.sv
// Host end of the external bus port: master toward the device, host-space slave
`timescale 1ns/1ps
module xbp_host
    import xbp_pkg::*;
(
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    // Bus ownership granted to the host
    input  wire logic        HOST_MASTER,
    // Master request
    input  wire logic        REQ_VALID,
    output logic             REQ_READY,
    input  wire logic        REQ_WRITE,
    input  wire logic [1:0]  REQ_LANES,
    input  wire logic        REQ_BURST,
    input  wire logic [31:0] REQ_ADDR,
    input  wire logic [63:0] REQ_WDATA,
    output logic             RD_VALID,
    output logic [63:0]      RD_DATA,
    // Host-space slave
    input  wire logic        SLV_WAIT,
    output logic             SLV_DONE,
    // Bus
    xbp_if.host_end          bus
);
    typedef struct packed {
        xbp_end_t                             e;
        logic [`XBP_HMEM_AW-1:0]              sidx;
        logic [(1<<`XBP_HMEM_AW)-1:0][63:0]   mem;
    } xbp_host_st_t;

    xbp_host_st_t st;
    xbp_host_st_t next_st;
    logic         slv_act;

    assign REQ_READY = HOST_MASTER && (st.e.mst == M_IDLE);
    assign slv_act   = !HOST_MASTER && !st.e.c2[0] && !(&st.e.c2[5:3]);

    always_comb begin
        next_st = st;
        next_st.e.a1 = bus.addr;
        next_st.e.a2 = st.e.a1;
        next_st.e.d1 = bus.data;
        next_st.e.d2 = st.e.d1;
        next_st.e.c1 = {bus.rd_n, bus.wrl_n, bus.wrh_n, bus.burst_indicator_n_n, bus.ack, bus.msh_n};
        next_st.e.c2 = st.e.c1;
        next_st.e.rvalid = 1'b0;
        next_st.e.sdone  = 1'b0;

        unique case (st.e.mst)
            M_IDLE: begin
                if (REQ_VALID && REQ_READY) begin
                    next_st.e.addr    = REQ_ADDR;
                    next_st.e.wdata   = REQ_WDATA;
                    next_st.e.write   = REQ_WRITE;
                    next_st.e.data_oe = REQ_WRITE;
                    next_st.e.rd_n    = REQ_WRITE;
                    next_st.e.wrl_n   = !(REQ_WRITE && REQ_LANES[0]);
                    next_st.e.wrh_n   = !(REQ_WRITE && REQ_LANES[1]);
                    next_st.e.burst_indicator_n_n  = !REQ_BURST;
                    next_st.e.cnt     = 4'h0;
                    next_st.e.mst     = M_WAIT;
                end
            end
            M_WAIT: begin
                if (st.e.cnt != `XBP_CNT_MAX) begin
                    next_st.e.cnt = st.e.cnt + 4'h1;
                end
                if ((st.e.cnt >= `XBP_ACK_SETTLE - 4'h1) && st.e.c2[1]) begin
                    next_st.e.rdata  = st.e.d2;
                    next_st.e.rvalid = !st.e.write;
                    next_st.e.rd_n   = 1'b1;
                    next_st.e.wrl_n  = 1'b1;
                    next_st.e.wrh_n  = 1'b1;
                    next_st.e.cnt    = 4'h0;
                    next_st.e.mst    = M_GAP;
                end
            end
            M_GAP: begin
                next_st.e.cnt = st.e.cnt + 4'h1;
                if (st.e.cnt == `XBP_GAP_CYC - 4'h1) begin
                    next_st.e.data_oe = 1'b0;
                    next_st.e.mst     = M_IDLE;
                end
            end
        endcase

        next_st.e.sact  = slv_act;
        next_st.e.ackoe = slv_act && SLV_WAIT;
        if (slv_act && !st.e.sact) begin
            if (!st.e.sburst) begin
                next_st.sidx = st.e.a2[`XBP_HMEM_AW-1:0];
            end
            next_st.e.sburst = !st.e.c2[2];
        end
        if (slv_act) begin
            next_st.e.shold  = st.e.d2;
            next_st.e.slanes = {!st.e.c2[3], !st.e.c2[4]};
        end
        next_st.e.sdoe  = slv_act && !st.e.c2[5];
        next_st.e.sdout = st.mem[st.sidx];
        if (!slv_act && st.e.sact) begin
            if (st.e.slanes[0]) begin
                next_st.mem[st.sidx][`XBP_HALF_W-1:0] = st.e.shold[`XBP_HALF_W-1:0];
            end
            if (st.e.slanes[1]) begin
                next_st.mem[st.sidx][`XBP_DATA_W-1:`XBP_HALF_W] =
                    st.e.shold[`XBP_DATA_W-1:`XBP_HALF_W];
            end
            next_st.sidx    = st.sidx + 1'b1;
            next_st.e.sdone = 1'b1;
        end
        if (!st.e.sact && !slv_act && st.e.c2[2]) begin
            next_st.e.sburst = 1'b0;
        end

        if (!RST_N) begin
            next_st.e.mst     = M_IDLE;
            next_st.e.cnt     = 4'h0;
            next_st.e.write   = 1'b0;
            next_st.e.data_oe = 1'b0;
            next_st.e.rd_n    = 1'b1;
            next_st.e.wrl_n   = 1'b1;
            next_st.e.wrh_n   = 1'b1;
            next_st.e.burst_indicator_n_n  = 1'b1;
            next_st.e.addr    = '0;
            next_st.e.wdata   = '0;
            next_st.e.rdata   = '0;
            next_st.e.sact    = 1'b0;
            next_st.e.sburst  = 1'b0;
            next_st.e.sdoe    = 1'b0;
            next_st.e.ackoe   = 1'b0;
            next_st.e.slanes  = 2'h0;
            next_st.sidx      = '0;
        end
    end

    always_ff @(posedge MCLK) begin
        st <= next_st;
    end

    assign bus.h_ctl_oe  = HOST_MASTER && RST_N;
    assign bus.h_data_oe = (HOST_MASTER && RST_N && st.e.data_oe) || st.e.sdoe;
    assign bus.h_addr    = st.e.addr;
    assign bus.h_data    = st.e.sdoe ? st.e.sdout : st.e.wdata;
    assign bus.h_rd_n    = st.e.rd_n;
    assign bus.h_wrl_n   = st.e.wrl_n;
    assign bus.h_wrh_n   = st.e.wrh_n;
    assign bus.h_burst_indicator_n_n  = st.e.burst_indicator_n_n;
    assign bus.h_ack_oe  = st.e.ackoe && RST_N;

    assign RD_VALID = st.e.rvalid;
    assign RD_DATA  = st.e.rdata;
    assign SLV_DONE = st.e.sdone;
endmodule : xbp_host

// File: tb/xbp_assertions.sv
// Checker on the resolved external bus wires
`timescale 1ns/1ps
`include "xbp_defs.svh"
module xbp_assertions (
    // Clock and reset
    input wire logic        MCLK,
    input wire logic        RST_N,
    // Resolved bus
    input wire logic [31:0] addr,
    input wire logic [63:0] data,
    input wire logic        rd_n,
    input wire logic        wrl_n,
    input wire logic        wrh_n,
    input wire logic        ms0_n,
    input wire logic        ms1_n,
    input wire logic        msh_n,
    input wire logic        ack,
    // Device drive enables
    input wire logic        d_ctl_oe,
    input wire logic        d_ack_oe
);
    logic act;
    assign act = !(rd_n & wrl_n & wrh_n);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    property p_bank0; d_ctl_oe |-> ms0_n == (addr[31:27] != `XBP_BANK0_CODE); endproperty
    a_bank0: assert property (p_bank0) else $error("bank0 select wrong");
    property p_bank1; d_ctl_oe |-> ms1_n == (addr[31:27] != `XBP_BANK1_CODE); endproperty
    a_bank1: assert property (p_bank1) else $error("bank1 select wrong");
    property p_host; d_ctl_oe |-> msh_n == !addr[31]; endproperty
    a_host: assert property (p_host) else $error("host select wrong");
    property p_stand; act && $past(act) |-> $stable(addr) && $stable({ms0_n, ms1_n}); endproperty
    a_stand: assert property (p_stand) else $error("address moved under strobe");
    property p_min; $rose(act) |-> act [*8]; endproperty
    a_min: assert property (p_min) else $error("strobe too short");
    property p_wait; !ack [*4] ##0 act |=> act; endproperty
    a_wait: assert property (p_wait) else $error("strobe ended during wait");
    property p_slvack; d_ack_oe |-> !d_ctl_oe; endproperty
    a_slvack: assert property (p_slvack) else $error("master pulled ack");
    property p_data; (d_ctl_oe && !wrl_n) [*4] |-> $stable(data); endproperty
    a_data: assert property (p_data) else $error("write data moved");
endmodule : xbp_assertions

// File: tb/external_bus_port_controls_tb.sv
// Bench joining device and host ends over the shared bus
`timescale 1ns/1ps
module external_bus_port_controls_tb;
    import xbp_pkg::*;
    logic        clk = 0, rst_n = 0, bm = 1, hm = 0, dv = 0, hv = 0, en = 0;
    logic        wr = 0, lng = 0, z32 = 0, bt = 0, bst = 0, rrdy = 0, sw = 0, hw = 0;
    logic [1:0]  ln = 0;
    logic [31:0] a = 0;
    logic [63:0] wd = 0;
    logic [15:0] lf = 16'h0027;
    logic        drdy, hrdy, dvld, hvld, strap;
    logic [63:0] drd, hrd, dq[$], hq[$], hmem[4], dmem[16];
    int          err_count = 0, num_checks = 0;

    xbp_if bus ();
    xbp_device i_xbp_device (.MCLK(clk), .RST_N(rst_n), .BUS_MASTER(bm), .REQ_VALID(dv),
        .REQ_READY(drdy), .REQ_WRITE(wr), .REQ_LONG(lng), .REQ_ZONE32(z32), .REQ_BOOT(bt),
        .REQ_BURST(bst), .REQ_ADDR(a), .REQ_WDATA(wd), .XFER_DONE(), .RD_VALID(dvld),
        .RD_READY(rrdy), .RD_DATA(drd), .SLV_WAIT(sw), .SLV_DONE(), .SLV_INDEX(),
        .EPROM_BOOT_STRAP(strap), .bus(bus));
    xbp_host i_xbp_host (.MCLK(clk), .RST_N(rst_n), .HOST_MASTER(hm), .REQ_VALID(hv),
        .REQ_READY(hrdy), .REQ_WRITE(wr), .REQ_LANES(ln), .REQ_BURST(bst), .REQ_ADDR(a),
        .REQ_WDATA(wd), .RD_VALID(hvld), .RD_DATA(hrd), .SLV_WAIT(hw), .SLV_DONE(), .bus(bus));
    xbp_assertions i_xbp_assertions (.MCLK(clk), .RST_N(rst_n), .addr(bus.addr),
        .data(bus.data), .rd_n(bus.rd_n), .wrl_n(bus.wrl_n), .wrh_n(bus.wrh_n),
        .ms0_n(bus.ms0_n), .ms1_n(bus.ms1_n), .msh_n(bus.msh_n), .ack(bus.ack),
        .d_ctl_oe(bus.d_ctl_oe), .d_ack_oe(bus.d_ack_oe));

    always #10 clk = ~clk;

    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nx

    // Random ready and slave stalls keep both wait paths busy
    always @(posedge clk) begin
        lf   <= nx(lf);
        rrdy <= en & lf[0];
        sw   <= lf[1];
        hw   <= lf[2];
    end

    task automatic chk(input string n, input logic [63:0] s, e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic close_out;
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    // One transfer by host (h) or device; model slot ix follows the lanes
    task automatic op(input logic h, w, l, z, b, input logic [1:0] n,
                      input logic [31:0] ad, input logic [3:0] ix);
        logic [63:0] v, m;
        logic        lo, hi;
        int          k;
        @(posedge clk);
        v = {lf, ~lf, lf, ~lf};
        lo = h ? n[0] : z | l | !ad[0];
        hi = h ? n[1] : !z & (l | ad[0]);
        m = h ? dmem[ix] : hmem[ix[1:0]];
        if (w && lo) m[31:0] = v[31:0];
        if (w && hi) m[63:32] = v[63:32];
        if (h | ad[31]) begin
            if (w && h) dmem[ix] = m;
            else if (w) hmem[ix[1:0]] = m;
            else if (h) hq.push_back(m);
            else dq.push_back(m);
        end
        {wr, lng, z32, bst, ln, a, wd} <= {w, l, z, b, n, ad, v};
        if (h) hv <= 1; else dv <= 1;
        k = 0;
        do begin @(posedge clk); k++; end while (!(h ? hrdy : drdy) && k < 300);
        if (k >= 300) chk("req_ready", 0, 1);
        dv <= 0;
        hv <= 0;
        k = 0;
        repeat (2) @(posedge clk);
        while (!(h ? hrdy : drdy) && k < 40) begin @(posedge clk); k++; end
    endtask : op

    always @(posedge clk) begin
        if (dvld & rrdy) chk("dev_rd", drd, dq.pop_front());
        if (hvld) chk("host_rd", hrd, hq.pop_front());
    end

    initial begin
        #200000;
        err_count++;
        close_out();
    end

    initial begin
        bus.bms_pull_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus.bms_pull_n <= 1'b1;
        for (int i = 0; i < 4; i++) op(0, 1, 1, 0, 0, 0, 32'h8000_0000 + i, i);
        op(0, 1, 0, 0, 0, 0, 32'h8000_0001, 1);
        op(0, 1, 0, 0, 0, 0, 32'h8000_0002, 2);
        op(0, 1, 0, 1, 0, 0, 32'h8000_0003, 3);
        bt <= 1;
        op(0, 1, 1, 0, 0, 0, 32'h3000_0000, 0);
        op(0, 1, 0, 0, 0, 0, 32'h3800_0001, 0);
        bt <= 0;
        // Eight reads with the sink stalled fill the return buffer
        for (int i = 0; i < 8; i++) op(0, 0, 0, 0, i < 3, 0, 32'h8000_0000 + i[1:0], i);
        @(posedge clk);
        chk("full", drdy, 0);
        en <= 1;
        repeat (60) @(posedge clk);
        chk("empty", dvld, 0);
        chk("strap", strap, 0);
        bm <= 0;
        @(posedge clk);
        hm <= 1;
        for (int i = 0; i < 4; i++) op(1, 1, 0, 0, 0, 3, i, i);
        op(1, 1, 0, 0, 0, 1, 1, 1);
        op(1, 1, 0, 0, 0, 2, 2, 2);
        for (int i = 0; i < 3; i++) op(1, 1, 0, 0, i < 2, 3, 8, 8 + i);
        for (int i = 0; i < 7; i++) op(1, 0, 0, 0, 0, 0, i + 4 * (i > 3), i + 4 * (i > 3));
        repeat (20) @(posedge clk);
        close_out();
    end
endmodule : external_bus_port_controls_tb
